//--- hdl/exc_ctrl_pkg.sv
package exc_ctrl_pkg;

  // line-count limits
  localparam int IRQ_ARCH_MAX = 496;              // architectural ceiling
  localparam int IRQ_CAP_SMALL = 240;             // common lower cap
  localparam int IRQ_IMPL_CAP = 480;              // cap of this implementation

  // exception numbering
  localparam int EXC_NUM_W = 9;
  typedef logic [EXC_NUM_W-1:0] exc_num_t;
  localparam exc_num_t EXC_THREAD = 9'h000;       // no exception active
  localparam exc_num_t EXC_RESET = 9'h001;
  localparam exc_num_t EXC_NMI = 9'h002;
  localparam exc_num_t EXC_FAULT = 9'h003;
  localparam exc_num_t EXC_IRQ_BASE = 9'h010;     // line n is number n + 16

  // fixed priorities, stored with an offset of four so -4 encodes as 0
  localparam logic [2:0] PRIO_OFS = 3'h4;
  localparam logic [2:0] ENC_RESET = 3'h0;        // -4
  localparam logic [2:0] ENC_FAULT_HI = 3'h1;     // -3
  localparam logic [2:0] ENC_NMI = 3'h2;          // -2
  localparam logic [2:0] ENC_FAULT_LO = 3'h3;     // -1

  // values after reset of each line's settings
  localparam logic PRIO_RST_VAL = 1'b0;           // every priority bit reads zero
  localparam logic EN_RST_VAL = 1'b0;             // every line disabled

  // vector table: one 32-bit word per exception number
  localparam int VEC_SHIFT = 2;

  typedef enum logic [1:0] {
    ST_BOOT,
    ST_IDLE,
    ST_FETCH
  } ctl_state_t;

endpackage

//--- hdl/prio_mem_if.sv
`timescale 1ns/10ps
// settings port between the controller and its per-line store
interface prio_mem_if #(
  parameter int DEPTH = 32,
  parameter int AW    = 5,
  parameter int DW    = 4
);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

//--- hdl/irq_cfg_mem.sv
`timescale 1ns/10ps
// per-line {enable, priority} store, one write and one registered read port
module irq_cfg_mem #(
  parameter int DEPTH = 32,
  parameter int AW    = 5,
  parameter int DW    = 4
) (
  input  wire logic   clk_i,    // core clock
  input  wire logic   rst_n_i,  // async reset, active low
  input  wire logic   ce_i,     // clock enable
  prio_mem_if.mem     bus       // write and read port
);

  logic [DW-1:0] cells_r [DEPTH];
  logic [DW-1:0] rdata_r;

  // reset clears all entries so every line starts disabled at priority zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < DEPTH; k++) begin
        cells_r[k] <= {exc_ctrl_pkg::EN_RST_VAL, {(DW-1){exc_ctrl_pkg::PRIO_RST_VAL}}}; // [R16]
      end
    end else if (ce_i && bus.we) begin
      cells_r[bus.waddr] <= bus.wdata;
    end
  end

  // read returns the old word when read and write meet at one address
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= '0;
    end else if (ce_i) begin
      rdata_r <= cells_r[bus.raddr];
    end
  end

  assign bus.rdata = rdata_r;

endmodule

//--- hdl/nested_vectored_irq_ctrl.sv
`timescale 1ns/10ps
// Summary of operation
// [R1] Accepts up to NUM_IRQ request lines, never above 496, capped here at 480.
// [R2] Line count is a design-time parameter chosen by the integrator.
// [R3] Priority field width per exception is a design-time parameter.
// [R4] Every handler runs on the main stack, whatever thread used.
// [R5] Handler execution is always privileged.
// [R6] Thread mode privilege and stack choice come from two configuration inputs.
// [R7] Unprivileged thread cannot change line settings; attempts are flagged.
// [R8] A strictly more urgent pending enabled exception pre-empts the running handler.
// [R9] On acceptance the vector word is fetched and the core branches to it.
// [R10] A request line edge pends the line; the task is suspended for it.
// [R11] Exception return pops the nest and resumes the suspended code.
// [R12] Current execution priority and every exception's priority decide what runs.
// [R13] Lines carry an enable; NMI and escalated fault are always enabled.
// [R14] Numbers 1 to 15 are system exceptions; line n is number n plus 16.
// [R15] Reset is -4, NMI -2, escalated fault -1 or -3, all fixed.
// [R16] After reset every line is disabled with priority zero.
// [R17] Lower value is more urgent; ties go to the lowest exception number.
module nested_vectored_irq_ctrl #(
  parameter int NUM_IRQ    = 32,   // implemented request lines [R2]
  parameter int PRIO_BITS  = 3,    // implemented priority bits [R3]
  parameter bit FAULT_HIGH = 1'b0  // escalated fault at -3 instead of -1
) (
  input  wire logic                 CLK_I,          // core clock, 125 MHz
  input  wire logic                 RST_N_I,        // async reset, active low
  input  wire logic                 CE_I,           // clock enable, freezes all
  input  wire logic [NUM_IRQ-1:0]   IRQ_I,          // peripheral request lines
  input  wire logic                 NMI_I,          // non-maskable request
  input  wire logic                 FAULT_I,        // escalated fault request
  input  wire logic                 THR_UNPRIV_I,   // thread runs unprivileged
  input  wire logic                 THR_PSP_I,      // thread uses process stack
  input  wire logic                 CFG_WE_I,       // line settings write strobe
  input  wire logic [$clog2(NUM_IRQ)-1:0] CFG_IDX_I, // line index
  input  wire logic                 CFG_EN_I,       // new enable
  input  wire logic [PRIO_BITS-1:0] CFG_PRIO_I,     // new priority
  output logic                      CFG_DENIED_O,   // write refused, pulse
  input  wire logic [31:0]          VEC_BASE_I,     // vector table base
  output logic                      VEC_REQ_O,      // vector fetch request
  output logic [31:0]               VEC_ADDR_O,     // vector word address
  input  wire logic                 VEC_ACK_I,      // vector word valid
  input  wire logic [31:0]          VEC_DATA_I,     // vector word
  output logic                      BRANCH_O,       // branch to handler, pulse
  output logic [31:0]               BRANCH_ADDR_O,  // handler entry address
  output logic                      SUSPEND_O,      // task suspended, pulse
  output logic                      RESUME_O,       // suspended code resumes, pulse
  input  wire logic                 EXC_RETURN_I,   // handler finished, pulse
  output logic [8:0]                EXC_NUM_O,      // active exception number
  output logic [PRIO_BITS+1:0]      EXEC_PRIO_O,    // execution priority, +4 coded
  output logic                      HANDLER_O,      // handler mode
  output logic                      PRIV_O,         // privileged now
  output logic                      USE_PSP_O       // process stack selected
);

  localparam int IDX_W = $clog2(NUM_IRQ);
  localparam int EP_W = PRIO_BITS + 2;
  localparam int MW = PRIO_BITS + 1;
  localparam int STK_DEPTH = (1 << PRIO_BITS) + 3;
  localparam int SP_W = $clog2(STK_DEPTH + 1);

  typedef logic [EP_W-1:0] ep_t;
  typedef exc_ctrl_pkg::exc_num_t num_t;

  localparam ep_t EP_THREAD = '1;
  localparam ep_t EP_NMI = ep_t'(exc_ctrl_pkg::ENC_NMI);                       // [R15]
  localparam ep_t EP_FAULT = FAULT_HIGH ? ep_t'(exc_ctrl_pkg::ENC_FAULT_HI)
                                        : ep_t'(exc_ctrl_pkg::ENC_FAULT_LO);  // [R15]
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(NUM_IRQ - 1);

  // elaboration guard on the line count
  if (NUM_IRQ > exc_ctrl_pkg::IRQ_IMPL_CAP || NUM_IRQ < 2) begin : g_bad_count // [R1]
    $error("request line count out of range");
  end

  // a beats b when more urgent, or equally urgent with a lower number
  function automatic logic beats(input logic av, input ep_t ap, input num_t an,
                                 input logic bv, input ep_t bp, input num_t bn);
    return av && (!bv || (ap < bp) || ((ap == bp) && (an < bn)));     // [R17]
  endfunction

  function automatic logic [31:0] vec_of(input logic [31:0] base, input num_t n);
    return base + {{(32 - exc_ctrl_pkg::EXC_NUM_W - exc_ctrl_pkg::VEC_SHIFT){1'b0}},
                   n, {exc_ctrl_pkg::VEC_SHIFT{1'b0}}};
  endfunction

  exc_ctrl_pkg::ctl_state_t state_r;
  logic [NUM_IRQ-1:0] irq_s1_r, irq_s2_r, irq_s3_r, pend_r, irq_rise_w, irq_clr_w;
  logic               nmi_s1_r, nmi_s2_r, nmi_s3_r, nmi_pend_r;
  logic               flt_s1_r, flt_s2_r, flt_s3_r, flt_pend_r;
  logic [IDX_W-1:0]   scan_idx_r, rd_idx_r, best_idx_r, win_idx_r;
  logic               rd_valid_r, best_v_r, win_v_r;
  ep_t                best_p_r, win_p_r, hit_ep_w;
  logic               hit_w, better_w, restart_w, cfg_wr_w, cfg_in_rng_w;
  num_t               snum_r [STK_DEPTH];
  ep_t                sprio_r [STK_DEPTH];
  logic [SP_W-1:0]    sp_r, pop_idx_w;
  num_t               cur_num_r, win_num_w, s1_n_w, sel_n_w;
  ep_t                cur_prio_r, s1_p_w, sel_p_w;
  logic               idle_w, ret_w, take_w, take_irq_w, take_nmi_w, take_flt_w;
  logic               win_live_w, first_nmi_w, irq_wins_w, s1_v_w, sel_v_w;
  logic               handler_r, handler_nxt, priv_r, psp_r;
  logic               branch_r, suspend_r, resume_r, denied_r;
  logic [31:0]        vec_addr_r, branch_addr_r;

  prio_mem_if #(.DEPTH(NUM_IRQ), .AW(IDX_W), .DW(MW)) mem_bus ();

  irq_cfg_mem #(.DEPTH(NUM_IRQ), .AW(IDX_W), .DW(MW)) u_cfg_mem (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .ce_i    (CE_I),
    .bus     (mem_bus.mem)
  );

  // settings writes are honoured only while privileged
  assign cfg_in_rng_w = ({1'b0, CFG_IDX_I} < (IDX_W + 1)'(NUM_IRQ));
  assign cfg_wr_w = CFG_WE_I && priv_r && cfg_in_rng_w;                      // [R7]
  assign mem_bus.we = cfg_wr_w;
  assign mem_bus.waddr = CFG_IDX_I;
  assign mem_bus.wdata = {CFG_EN_I, CFG_PRIO_I};
  assign mem_bus.raddr = scan_idx_r;

  // request synchronisers; only the second and third stages feed logic
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      {irq_s1_r, irq_s2_r, irq_s3_r} <= '0;
      {nmi_s1_r, nmi_s2_r, nmi_s3_r, flt_s1_r, flt_s2_r, flt_s3_r} <= '0;
    end else if (CE_I) begin
      {irq_s3_r, irq_s2_r, irq_s1_r} <= {irq_s2_r, irq_s1_r, IRQ_I};
      {nmi_s3_r, nmi_s2_r, nmi_s1_r} <= {nmi_s2_r, nmi_s1_r, NMI_I};
      {flt_s3_r, flt_s2_r, flt_s1_r} <= {flt_s2_r, flt_s1_r, FAULT_I};
    end
  end

  // a rising request pends its line; a new edge beats the clear of acceptance
  assign irq_rise_w = irq_s2_r & ~irq_s3_r;                                   // [R10]
  assign irq_clr_w = NUM_IRQ'(take_irq_w) << win_idx_r;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pend_r <= '0;
      nmi_pend_r <= 1'b0;
      flt_pend_r <= 1'b0;
    end else if (CE_I) begin
      pend_r <= (pend_r & ~irq_clr_w) | irq_rise_w;                           // [R10]
      nmi_pend_r <= (nmi_pend_r && !take_nmi_w) || (nmi_s2_r && !nmi_s3_r);   // [R13]
      flt_pend_r <= (flt_pend_r && !take_flt_w) || (flt_s2_r && !flt_s3_r);   // [R13]
    end
  end

  // sweep the line store one entry a cycle; a sweep takes NUM_IRQ + 1 cycles,
  // traded for a single read port instead of a wide comparator tree;
  // a fresh edge restarts it so a part sweep never wins a tie, a steady stream delays entry
  assign hit_w = rd_valid_r && pend_r[rd_idx_r] && mem_bus.rdata[PRIO_BITS]; // [R13]
  assign hit_ep_w = ep_t'(mem_bus.rdata[PRIO_BITS-1:0]) + ep_t'(exc_ctrl_pkg::PRIO_OFS);
  assign better_w = hit_w && (!best_v_r || (hit_ep_w < best_p_r));           // [R17]
  assign restart_w = cfg_wr_w || take_irq_w || (|irq_rise_w);                 // [R17]

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      {scan_idx_r, rd_idx_r, rd_valid_r} <= '0;
    end else if (CE_I) begin
      scan_idx_r <= (restart_w || scan_idx_r == IDX_LAST) ? '0 : scan_idx_r + 1'b1;
      rd_idx_r <= scan_idx_r;
      rd_valid_r <= !restart_w;
    end
  end

  // best of the running sweep, published as the winner at its last entry
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      {best_v_r, best_idx_r, best_p_r, win_v_r, win_idx_r, win_p_r} <= '0;
    end else if (CE_I) begin
      if (restart_w) begin
        best_v_r <= 1'b0;
        win_v_r <= 1'b0;
      end else if (rd_valid_r && rd_idx_r == IDX_LAST) begin
        win_v_r <= better_w || best_v_r;
        win_idx_r <= better_w ? rd_idx_r : best_idx_r;
        win_p_r <= better_w ? hit_ep_w : best_p_r;
        best_v_r <= 1'b0;
      end else if (better_w) begin
        {best_v_r, best_idx_r, best_p_r} <= {1'b1, rd_idx_r, hit_ep_w};
      end
    end
  end

  // pick among NMI, escalated fault and the winning line
  assign win_live_w = win_v_r && pend_r[win_idx_r];
  assign win_num_w = exc_ctrl_pkg::EXC_IRQ_BASE + num_t'(win_idx_r);         // [R14]
  assign first_nmi_w = beats(nmi_pend_r, EP_NMI, exc_ctrl_pkg::EXC_NMI,
                             flt_pend_r, EP_FAULT, exc_ctrl_pkg::EXC_FAULT);  // [R15]
  assign s1_v_w = nmi_pend_r || flt_pend_r;
  assign s1_p_w = first_nmi_w ? EP_NMI : EP_FAULT;
  assign s1_n_w = first_nmi_w ? exc_ctrl_pkg::EXC_NMI : exc_ctrl_pkg::EXC_FAULT;
  assign irq_wins_w = beats(win_live_w, win_p_r, win_num_w, s1_v_w, s1_p_w, s1_n_w);
  assign sel_v_w = s1_v_w || win_live_w;
  assign sel_p_w = irq_wins_w ? win_p_r : s1_p_w;
  assign sel_n_w = irq_wins_w ? win_num_w : s1_n_w;

  // return is served before a new entry in the same cycle
  assign idle_w = (state_r == exc_ctrl_pkg::ST_IDLE);
  assign ret_w = idle_w && EXC_RETURN_I && handler_r;                         // [R11]
  assign take_w = idle_w && !ret_w && sel_v_w && (sel_p_w < cur_prio_r)
                  && (sp_r < SP_W'(STK_DEPTH));                              // [R8]
  assign take_irq_w = take_w && irq_wins_w;
  assign take_nmi_w = take_w && !irq_wins_w && first_nmi_w;
  assign take_flt_w = take_w && !irq_wins_w && !first_nmi_w;
  assign pop_idx_w = sp_r - SP_W'(1);
  assign handler_nxt = take_w || (handler_r && !(ret_w && sp_r == SP_W'(1)));

  // entry sequencer: reset vector first, then fetch per accepted exception
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_r <= exc_ctrl_pkg::ST_BOOT;
      vec_addr_r <= '0;
    end else if (CE_I) begin
      case (state_r)
        exc_ctrl_pkg::ST_BOOT: begin
          vec_addr_r <= vec_of(VEC_BASE_I, exc_ctrl_pkg::EXC_RESET);
          state_r <= exc_ctrl_pkg::ST_FETCH;
        end
        exc_ctrl_pkg::ST_FETCH: begin
          if (VEC_ACK_I) state_r <= exc_ctrl_pkg::ST_IDLE;
        end
        default: begin
          if (take_w) begin
            vec_addr_r <= vec_of(VEC_BASE_I, sel_n_w);                        // [R9]
            state_r <= exc_ctrl_pkg::ST_FETCH;
          end
        end
      endcase
    end
  end

  // nest of suspended contexts; the running one sits in cur_*_r
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int k = 0; k < STK_DEPTH; k++) begin
        snum_r[k] <= exc_ctrl_pkg::EXC_THREAD;
        sprio_r[k] <= EP_THREAD;
      end
      sp_r <= '0;
      cur_num_r <= exc_ctrl_pkg::EXC_THREAD;
      cur_prio_r <= EP_THREAD;
    end else if (CE_I) begin
      if (take_w) begin
        snum_r[sp_r] <= cur_num_r;                                            // [R12]
        sprio_r[sp_r] <= cur_prio_r;
        cur_num_r <= sel_n_w;
        cur_prio_r <= sel_p_w;
        sp_r <= sp_r + SP_W'(1);
      end else if (ret_w) begin
        cur_num_r <= snum_r[pop_idx_w];                                       // [R11]
        cur_prio_r <= sprio_r[pop_idx_w];
        sp_r <= pop_idx_w;
      end
    end
  end

  // mode outputs; thread settings take effect one cycle after they change
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      {handler_r, psp_r} <= '0;
      priv_r <= 1'b1;
    end else if (CE_I) begin
      handler_r <= handler_nxt;
      priv_r <= handler_nxt || !THR_UNPRIV_I;                                 // [R5] [R6]
      psp_r <= !handler_nxt && THR_PSP_I;                                     // [R4] [R6]
    end
  end

  // one-cycle event outputs
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      {branch_r, suspend_r, resume_r, denied_r, branch_addr_r} <= '0;
    end else if (CE_I) begin
      branch_r <= (state_r == exc_ctrl_pkg::ST_FETCH) && VEC_ACK_I;          // [R9]
      if ((state_r == exc_ctrl_pkg::ST_FETCH) && VEC_ACK_I) branch_addr_r <= VEC_DATA_I;
      suspend_r <= take_w && !handler_r;                                      // [R10]
      resume_r <= ret_w;                                                      // [R11]
      denied_r <= CFG_WE_I && !priv_r;                                        // [R7]
    end
  end

  assign VEC_REQ_O = (state_r == exc_ctrl_pkg::ST_FETCH);
  assign VEC_ADDR_O = vec_addr_r;
  assign BRANCH_O = branch_r;
  assign BRANCH_ADDR_O = branch_addr_r;
  assign SUSPEND_O = suspend_r;
  assign RESUME_O = resume_r;
  assign CFG_DENIED_O = denied_r;
  assign EXC_NUM_O = cur_num_r;
  assign EXEC_PRIO_O = cur_prio_r;
  assign HANDLER_O = handler_r;
  assign PRIV_O = priv_r;
  assign USE_PSP_O = psp_r;

  handler_priv_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [R5]
    HANDLER_O |-> PRIV_O) else $error("handler running unprivileged");
  handler_msp_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [R4]
    HANDLER_O |-> !USE_PSP_O) else $error("handler on process stack");
  cfg_block_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [R7]
    CE_I && CFG_WE_I && !PRIV_O |-> !mem_bus.we ##1 CFG_DENIED_O)
    else $error("unprivileged settings write not refused");
  nest_prio_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [R8]
    CE_I && take_w |=> EXEC_PRIO_O < $past(EXEC_PRIO_O) && HANDLER_O)
    else $error("entry without higher priority");
  vec_fetch_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [R9]
    CE_I && take_w |=> VEC_REQ_O && VEC_ADDR_O == vec_of($past(VEC_BASE_I), EXC_NUM_O))
    else $error("wrong vector address");
  vec_branch_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [R9]
    CE_I && VEC_REQ_O && VEC_ACK_I |=> BRANCH_O && BRANCH_ADDR_O == $past(VEC_DATA_I))
    else $error("branch does not follow vector word");
  resume_ctx_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [R11]
    CE_I && ret_w |=> RESUME_O && EXEC_PRIO_O == $past(sprio_r[pop_idx_w]))
    else $error("return did not restore context");
  irq_map_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [R14]
    CE_I && take_irq_w |=> EXC_NUM_O == exc_ctrl_pkg::EXC_IRQ_BASE + num_t'($past(win_idx_r)))
    else $error("line to exception number mismatch");
  nmi_fixed_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [R15]
    idle_w && !ret_w && nmi_pend_r && !(FAULT_HIGH && flt_pend_r) && cur_prio_r > EP_NMI
    |-> take_nmi_w) else $error("pending NMI not taken");
  scan_tie_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [R17]
    CE_I && hit_w && best_v_r && hit_ep_w == best_p_r && !restart_w
    && rd_idx_r != IDX_LAST |=> best_idx_r == $past(best_idx_r))
    else $error("tie not kept by lower number");

endmodule

//--- verification/vec_fetch_model.sv
`timescale 1ns/10ps
// memory side of the vector fetch, answering after a chosen wait
module vec_fetch_model #(
  parameter logic [31:0] KEY = 32'h5A5A_0000  // arbitrary table contents marker
) (
  input  wire logic        clk_i,    // core clock
  input  wire logic        rst_n_i,  // async reset, active low
  input  wire logic [3:0]  dly_i,    // extra wait cycles
  input  wire logic        req_i,    // fetch pending
  input  wire logic [31:0] addr_i,   // vector word address
  output logic             ack_o,    // word valid
  output logic [31:0]      data_o    // word read
);
  logic [3:0] wait_r;
  // the bus toggles between answers so stale data never passes as valid
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o  <= 1'b0;
      data_o <= 32'h0000_0000;
      wait_r <= 4'h0;
    end else if (req_i && !ack_o && wait_r >= dly_i) begin
      ack_o  <= 1'b1;
      data_o <= addr_i ^ KEY;
      wait_r <= 4'h0;
    end else begin
      ack_o  <= 1'b0;
      data_o <= ~data_o;
      wait_r <= (req_i && !ack_o) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule

//--- verification/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module tb_top;
  localparam logic [31:0] BASE = 32'h0000_8000;
  logic        clk = 1'b0, rst_n = 1'b0, nmi = 1'b0, fault = 1'b0, unpriv = 1'b0, ce = 1'b1;
  logic        psp = 1'b0, cfg_we = 1'b0, cfg_en = 1'b0, exc_ret = 1'b0;
  logic        vreq, vack, branch, suspend, resume, denied, handler, priv, use_psp;
  logic [31:0] irq = 32'h0000_0000;
  logic [4:0]  cfg_idx = 5'h00;
  logic [2:0]  cfg_prio = 3'h0, p7;
  logic [3:0]  dly = 4'h0;
  logic [31:0] vaddr, vdata, br_addr;
  logic [8:0]  exc_num, mon_n;
  logic [4:0]  exec_prio;
  logic [8:0]  exp_q[$];
  int          num_errors = 0, num_checks = 0, num_br = 0, n_exp = 0, num_susp = 0;

  always #4 clk = ~clk;

  nested_vectored_irq_ctrl dut_u (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .IRQ_I(irq),
    .NMI_I(nmi), .FAULT_I(fault), .THR_UNPRIV_I(unpriv), .THR_PSP_I(psp),
    .CFG_WE_I(cfg_we), .CFG_IDX_I(cfg_idx), .CFG_EN_I(cfg_en), .CFG_PRIO_I(cfg_prio),
    .CFG_DENIED_O(denied), .VEC_BASE_I(BASE), .VEC_REQ_O(vreq), .VEC_ADDR_O(vaddr),
    .VEC_ACK_I(vack), .VEC_DATA_I(vdata), .BRANCH_O(branch), .BRANCH_ADDR_O(br_addr),
    .SUSPEND_O(suspend), .RESUME_O(resume), .EXC_RETURN_I(exc_ret), .EXC_NUM_O(exc_num),
    .EXEC_PRIO_O(exec_prio), .HANDLER_O(handler), .PRIV_O(priv), .USE_PSP_O(use_psp));

  vec_fetch_model pm_u (.clk_i(clk), .rst_n_i(rst_n), .dly_i(dly), .req_i(vreq),
    .addr_i(vaddr), .ack_o(vack), .data_o(vdata));

  // each branch is matched against the oldest outstanding entry
  always @(posedge clk) begin
    if (suspend === 1'b1) num_susp++;
    if (branch === 1'b1) begin
      num_br++;
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("[ERR] %0t branch not expected", $time);
      end else begin
        mon_n = exp_q.pop_front();
        `CHK(br_addr, (BASE + {mon_n, 2'b00}) ^ 32'h5A5A_0000)
        if (mon_n != 9'h001) `CHK(exc_num, mon_n)
      end
    end
  end

  task automatic expect_entry(input logic [8:0] n);
    exp_q.push_back(n);
    n_exp++;
    dly <= 4'($urandom_range(0, 5));
  endtask

  // bounded wait: entry may take two full sweeps after the edge
  task automatic wait_br();
    for (int i = 0; i < 400 && num_br < n_exp; i++) begin
      @(posedge clk);
      #1;
    end
    if (num_br < n_exp) begin
      num_errors++;
      $display("[ERR] %0t no branch", $time);
    end
  endtask

  task automatic cfg(input logic [4:0] i, input logic e, input logic [2:0] p);
    @(posedge clk);
    cfg_we <= 1'b1;
    cfg_idx <= i;
    cfg_en <= e;
    cfg_prio <= p;
    @(posedge clk);
    cfg_we <= 1'b0;
  endtask

  task automatic ret();
    @(posedge clk);
    exc_ret <= 1'b1;
    @(posedge clk);
    exc_ret <= 1'b0;
    #1;
    `CHK(resume, 1'b1)
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #(20000 * 8);
    num_errors++;
    results();
  end

  initial begin
    void'($urandom(26271));
    expect_entry(9'h001);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    wait_br();
    `CHK(handler, 1'b0)
    `CHK(exec_prio, 5'h1F)
    cfg(5'h02, 1'b1, 3'h3);
    cfg(5'h05, 1'b1, 3'h3);
    p7 = 3'($urandom_range(0, 2));
    cfg(5'h07, 1'b1, p7);
    unpriv <= 1'b1;
    psp <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK(priv, 1'b0)
    `CHK(use_psp, 1'b1)
    cfg(5'h09, 1'b1, 3'h0);
    #1;
    `CHK(denied, 1'b1)
    // peripherals raise lines together; equal priority goes to lowest number
    @(posedge clk);
    irq <= 32'h0000_0224;
    expect_entry(9'h012);
    wait_br();
    `CHK(handler, 1'b1)
    `CHK(priv, 1'b1)
    `CHK(use_psp, 1'b0)
    `CHK(exec_prio, 5'h07)
    @(posedge clk);
    irq[7] <= 1'b1;
    expect_entry(9'h017);
    wait_br();
    `CHK(exec_prio, 5'(p7) + 5'h04)
    @(posedge clk);
    nmi <= 1'b1;
    fault <= 1'b1;
    expect_entry(9'h002);
    wait_br();
    `CHK(exec_prio, 5'h02)
    expect_entry(9'h003);
    ret();
    wait_br();
    `CHK(exec_prio, 5'h03)
    ret();
    `CHK(exc_num, 9'h017)
    ret();
    `CHK(exc_num, 9'h012)
    expect_entry(9'h015);
    ret();
    wait_br();
    `CHK(exec_prio, 5'h07)
    // a frozen controller must let a return pulse pass unseen
    @(posedge clk);
    ce <= 1'b0;
    exc_ret <= 1'b1;
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    exc_ret <= 1'b0;
    #1;
    `CHK(resume, 1'b0)
    `CHK(handler, 1'b1)
    ret();
    `CHK(handler, 1'b0)
    repeat (150) @(posedge clk);
    `CHK(num_br, n_exp)
    `CHK(num_susp, 2)
    results();
  end
endmodule
